// file: rtl/aor_router.v
/*
  Dual-path output audio router: tone bank, two LTC coders, sixteen-input flex
  mixer onto buses A-P, crosspoints for 32 embedded and 2 AES channels with
  gain, invert, mute and peak meters. Samples leave through an 8-word FIFO.
  Assumes SAMPLE_STB_I pulses once per audio sample, far apart enough for the
  50-slot pass; settings are static levels from the control processor.
*/
`timescale 1ns/1ps
`include "aor_map.vh"
module aor_router (
  input wire CLOCK_I,
  input wire ARST_N_I,
  input wire SAMPLE_STB_I,
  input wire TC_LOST_I,
  input wire MUTE_ON_LOSS_I,
  input wire [`AOR_LTC_BITS-1:0] LTC_TC_P1_I,
  input wire [`AOR_LTC_BITS-1:0] LTC_TC_P2_I,
  input wire [`AOR_NCH*`AOR_MSRC_W-1:0] MIX_SRC_I,
  input wire [`AOR_NCH*`AOR_BUS_W-1:0] MIX_BUS_I,
  input wire [`AOR_NCH*`AOR_MGAIN_W-1:0] MIX_GAIN_I,
  input wire [`AOR_NCH-1:0] MIX_MUTE_I,
  input wire [`AOR_NEMB*`AOR_SRC_W-1:0] EMB_SRC_I,
  input wire [`AOR_NEMB*`AOR_EGAIN_W-1:0] EMB_GAIN_I,
  input wire [`AOR_NEMB-1:0] EMB_MUTE_I,
  input wire [`AOR_NEMB-1:0] EMB_INV_I,
  input wire [3:0] GRP_EN_I,
  input wire [2*`AOR_SRC_W-1:0] AES_SRC_P1_I,
  input wire [2*`AOR_SRC_W-1:0] AES_SRC_P2_I,
  input wire [1:0] AES_PATH_I,
  input wire [2*`AOR_EGAIN_W-1:0] AES_GAIN_I,
  input wire [1:0] AES_MUTE_I,
  input wire [1:0] AES_INV_I,
  input wire PEAK_CLR_I,
  input wire OUT_READY_I,
  output reg OUT_VALID_O,
  output reg [`AOR_SMP_W-1:0] OUT_DATA_O,
  output reg [`AOR_CHAN_W-1:0] OUT_CHAN_O,
  output reg [`AOR_NOUT*`AOR_MAG_W-1:0] PEAK_O,
  output reg BUSY_O,
  output reg OVERRUN_O
);
  localparam S_IDLE = 1'b0;
  localparam S_RUN = 1'b1;
  localparam FW = `AOR_SMP_W + `AOR_CHAN_W;
  reg state_q;
  reg [5:0] slot_q;
  reg [3:0] grp_en_q;
  reg [`AOR_NCH*`AOR_PH_W-1:0] tone_ph_q;
  reg [`AOR_NCH*`AOR_ACC_W-1:0] bus_q;
  reg [`AOR_LTC_BITS-1:0] ltc_word_q [0:1];
  reg [6:0] ltc_bit_q [0:1];
  reg [3:0] ltc_cnt_q [0:1];
  reg [1:0] ltc_half_q;
  reg [1:0] ltc_lvl_q;
  reg ltc_mute_q;
  integer i;
  integer p;
  // Tone phase increment: f * 2^16 / 48000
  function [`AOR_PH_W-1:0] tone_inc;
    input [3:0] n;
    begin
      case (n)
        4'h0: tone_inc = 16'h0089;
        4'h1: tone_inc = 16'h0111;
        4'h2: tone_inc = 16'h019a;
        4'h3: tone_inc = 16'h0222;
        4'h4: tone_inc = 16'h02ab;
        4'h5: tone_inc = 16'h0333;
        4'h6: tone_inc = 16'h03bc;
        4'h7: tone_inc = 16'h0444;
        4'h8: tone_inc = 16'h04cd;
        4'h9: tone_inc = 16'h0555;
        4'ha: tone_inc = 16'h0aab;
        4'hb: tone_inc = 16'h1555;
        4'hc: tone_inc = 16'h2000;
        4'hd: tone_inc = 16'h2aab;
        4'he: tone_inc = 16'h4000;
        default: tone_inc = 16'h5555;
      endcase
    end
  endfunction
  // Whole-dB and tenth-dB factors, Q2.14
  function [15:0] whole_tab;
    input [2:0] n;
    begin
      case (n)
        3'd0: whole_tab = 16'h4000;
        3'd1: whole_tab = 16'h47cf;
        3'd2: whole_tab = 16'h5092;
        3'd3: whole_tab = 16'h5a67;
        3'd4: whole_tab = 16'h656f;
        default: whole_tab = 16'h71cf;
      endcase
    end
  endfunction
  function [15:0] tenth_tab;
    input [3:0] n;
    begin
      case (n)
        4'd0: tenth_tab = 16'h4000;
        4'd1: tenth_tab = 16'h40be;
        4'd2: tenth_tab = 16'h417e;
        4'd3: tenth_tab = 16'h4241;
        4'd4: tenth_tab = 16'h4305;
        4'd5: tenth_tab = 16'h43cc;
        4'd6: tenth_tab = 16'h4495;
        4'd7: tenth_tab = 16'h4561;
        4'd8: tenth_tab = 16'h462e;
        default: tenth_tab = 16'h46ff;
      endcase
    end
  endfunction
  function [`AOR_SMP_W-1:0] sat24;
    input signed [47:0] v;
    begin
      if (v > $signed({24'h000000, `AOR_SMP_MAX})) begin
        sat24 = `AOR_SMP_MAX;
      end else if (v < $signed({24'hffffff, `AOR_SMP_MIN})) begin
        sat24 = `AOR_SMP_MIN;
      end else begin
        sat24 = v[`AOR_SMP_W-1:0];
      end
    end
  endfunction
  // Octave step taken as 6 dB; gives about 0.02 dB error per octave
  function [`AOR_SMP_W-1:0] gain_apply;
    input [`AOR_SMP_W-1:0] s;
    input [10:0] a;
    reg [10:0] k;
    reg [10:0] r;
    reg [10:0] d;
    reg signed [47:0] v;
    begin
      k = a / `AOR_GAIN_OCT;
      r = a - k * `AOR_GAIN_OCT;
      d = r / `AOR_GAIN_DB;
      v = $signed({{24{s[23]}}, s}) * $signed({32'h00000000, whole_tab(d[2:0])});
      v = v >>> `AOR_TAB_SHIFT;
      d = r % `AOR_GAIN_DB;
      v = v * $signed({32'h00000000, tenth_tab(d[3:0])});
      v = v >>> `AOR_TAB_SHIFT;
      if (k >= `AOR_GAIN_UNITY_K) begin
        v = v <<< (k - `AOR_GAIN_UNITY_K);
      end else begin
        v = v >>> (`AOR_GAIN_UNITY_K - k);
      end
      gain_apply = sat24(v);
    end
  endfunction
  function [`AOR_SMP_W-1:0] tone_smp;
    input msb;
    begin
      tone_smp = msb ? `AOR_TONE_AMP : (~`AOR_TONE_AMP + 1'b1);
    end
  endfunction
  // Source selection for one output channel
  reg [5:0] oc;
  reg [`AOR_SRC_W-1:0] osrc;
  reg [6:0] ogain;
  reg omute;
  reg oinv;
  reg oen;
  reg [`AOR_SMP_W-1:0] osel;
  reg [`AOR_SMP_W-1:0] ogn;
  reg [`AOR_SMP_W-1:0] ofin;
  reg [`AOR_MAG_W-1:0] omag;
  reg [5:0] bidx;
  reg [`AOR_SMP_W-1:0] oneg;
  reg [`AOR_MSRC_W-1:0] msrc;
  reg [`AOR_MSRC_W-1:0] mtone;
  reg [9:0] mgain;
  reg [`AOR_SMP_W-1:0] msel;
  reg [`AOR_SMP_W-1:0] mgn;
  always @* begin
    oc = slot_q - `AOR_SLOT_OUT0;
    osrc = {`AOR_SRC_W{1'b0}};
    ogain = 7'd0;
    omute = 1'b0;
    oinv = 1'b0;
    oen = 1'b1;
    bidx = 6'd0;
    osel = {`AOR_SMP_W{1'b0}};
    if (slot_q >= `AOR_SLOT_AES0) begin
      // AES channel applies the selection named by its path toggle
      osrc = AES_PATH_I[oc[0]] ? AES_SRC_P2_I[oc[0]*`AOR_SRC_W +: `AOR_SRC_W]
                               : AES_SRC_P1_I[oc[0]*`AOR_SRC_W +: `AOR_SRC_W];
      ogain = AES_GAIN_I[oc[0]*`AOR_EGAIN_W +: `AOR_EGAIN_W];
      omute = AES_MUTE_I[oc[0]];
      oinv = AES_INV_I[oc[0]];
    end else begin
      osrc = EMB_SRC_I[oc[4:0]*`AOR_SRC_W +: `AOR_SRC_W];
      ogain = EMB_GAIN_I[oc[4:0]*`AOR_EGAIN_W +: `AOR_EGAIN_W];
      omute = EMB_MUTE_I[oc[4:0]];
      oinv = EMB_INV_I[oc[4:0]];
      if (oc[4] == 1'b0) begin
        oen = grp_en_q[oc[3:2]];
      end
    end
    if (ogain > `AOR_EGAIN_MAX) begin
      ogain = `AOR_EGAIN_MAX;
    end
    if (osrc < `AOR_SRC_LTC1) begin
      osel = tone_smp(tone_ph_q[osrc[3:0]*`AOR_PH_W + `AOR_PH_W - 1]);
    end else if (osrc == `AOR_SRC_LTC1 || osrc == `AOR_SRC_LTC2) begin
      if (!ltc_mute_q) begin
        osel = tone_smp(ltc_lvl_q[osrc[0]]);
      end
    end else if (osrc <= `AOR_SRC_BUSN) begin
      bidx = osrc - `AOR_SRC_BUS0;
      osel = sat24({{20{bus_q[bidx*`AOR_ACC_W + `AOR_ACC_W - 1]}}, bus_q[bidx*`AOR_ACC_W +: `AOR_ACC_W]});
    end
    ogn = gain_apply(osel, {ogain, 3'b000} + {2'b00, ogain, 1'b0} + `AOR_GAIN_OFS);
    oneg = sat24(-$signed({{24{ogn[23]}}, ogn}));
    ofin = oinv ? oneg : ogn;
    omag = ogn[23] ? oneg[`AOR_MAG_W-1:0] : ogn[`AOR_MAG_W-1:0];
    if (omute) begin
      ofin = {`AOR_SMP_W{1'b0}};
    end
  end
  always @* begin
    msrc = MIX_SRC_I[slot_q[3:0]*`AOR_MSRC_W +: `AOR_MSRC_W];
    mtone = msrc - `AOR_MSRC_TONE1;
    mgain = MIX_GAIN_I[slot_q[3:0]*`AOR_MGAIN_W +: `AOR_MGAIN_W];
    if (mgain > `AOR_MGAIN_MAX) begin
      mgain = `AOR_MGAIN_MAX;
    end
    msel = {`AOR_SMP_W{1'b0}};
    if (msrc >= `AOR_MSRC_TONE1 && !MIX_MUTE_I[slot_q[3:0]]) begin
      msel = tone_smp(tone_ph_q[mtone[3:0]*`AOR_PH_W + `AOR_PH_W - 1]);
    end
    mgn = gain_apply(msel, {1'b0, mgain} + `AOR_GAIN_OFS);
  end
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [FW-1:0] fifo_out_data;
  wire in_out_slot = (state_q == S_RUN) && (slot_q >= `AOR_SLOT_OUT0);
  wire push = in_out_slot && oen;
  wire stall = push && !fifo_in_ready;
  wire fifo_pop = fifo_out_valid && (!OUT_VALID_O || OUT_READY_I);

  aor_fifo #(
    .WIDTH(FW),
    .DEPTH(`AOR_FIFO_DEPTH),
    .AW(`AOR_FIFO_AW)
  ) u_fifo (
    .clk_i(CLOCK_I),
    .arst_n_i(ARST_N_I),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i({oc, ofin}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  always @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      OUT_VALID_O <= 1'b0;
      OUT_DATA_O <= {`AOR_SMP_W{1'b0}};
      OUT_CHAN_O <= {`AOR_CHAN_W{1'b0}};
    end else if (fifo_pop) begin
      OUT_VALID_O <= 1'b1;
      OUT_DATA_O <= fifo_out_data[`AOR_SMP_W-1:0];
      OUT_CHAN_O <= fifo_out_data[FW-1:`AOR_SMP_W];
    end else if (OUT_READY_I) begin
      OUT_VALID_O <= 1'b0;
    end
  end

  // Sequencer: slots 0-15 mix into buses, 16-49 serve the output channels
  always @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_q <= S_IDLE;
      slot_q <= 6'd0;
      grp_en_q <= 4'h0;
      bus_q <= {(`AOR_NCH*`AOR_ACC_W){1'b0}};
      tone_ph_q <= {(`AOR_NCH*`AOR_PH_W){1'b0}};
      BUSY_O <= 1'b0;
      OVERRUN_O <= 1'b0;
    end else begin
      OVERRUN_O <= SAMPLE_STB_I && (state_q == S_RUN);
      case (state_q)
        S_IDLE: begin
          if (SAMPLE_STB_I) begin
            state_q <= S_RUN;
            BUSY_O <= 1'b1;
            slot_q <= 6'd0;
            // Enables taken once per sample; a change still glitches embedders
            grp_en_q <= GRP_EN_I;
            bus_q <= {(`AOR_NCH*`AOR_ACC_W){1'b0}};
            for (i = 0; i < `AOR_NCH; i = i + 1) begin
              tone_ph_q[i*`AOR_PH_W +: `AOR_PH_W] <= tone_ph_q[i*`AOR_PH_W +: `AOR_PH_W] + tone_inc(i[3:0]);
            end
          end
        end
        S_RUN: begin
          if (slot_q < `AOR_SLOT_OUT0) begin
            bus_q[MIX_BUS_I[slot_q[3:0]*`AOR_BUS_W +: `AOR_BUS_W]*`AOR_ACC_W +: `AOR_ACC_W] <=
              bus_q[MIX_BUS_I[slot_q[3:0]*`AOR_BUS_W +: `AOR_BUS_W]*`AOR_ACC_W +: `AOR_ACC_W] +
              {{4{mgn[23]}}, mgn};
          end
          if (!stall) begin
            if (slot_q == `AOR_SLOT_LAST) begin
              state_q <= S_IDLE;
              BUSY_O <= 1'b0;
            end else begin
              slot_q <= slot_q + 1'b1;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Peak meters hold the largest post-gain magnitude; clear yields to a new sample
  always @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      PEAK_O <= {(`AOR_NOUT*`AOR_MAG_W){1'b0}};
    end else begin
      if (PEAK_CLR_I) begin
        PEAK_O <= {(`AOR_NOUT*`AOR_MAG_W){1'b0}};
      end
      if (in_out_slot && !stall) begin
        if (PEAK_CLR_I || omag > PEAK_O[oc*`AOR_MAG_W +: `AOR_MAG_W]) begin
          PEAK_O[oc*`AOR_MAG_W +: `AOR_MAG_W] <= omag;
        end
      end
    end
  end

  // Biphase-mark LTC coder per path, advanced once per sample
  always @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ltc_half_q <= 2'b00;
      ltc_lvl_q <= 2'b00;
      ltc_mute_q <= 1'b0;
      for (p = 0; p < 2; p = p + 1) begin
        ltc_word_q[p] <= {`AOR_LTC_BITS{1'b0}};
        ltc_bit_q[p] <= 7'd0;
        ltc_cnt_q[p] <= 4'd0;
      end
    end else if (SAMPLE_STB_I && state_q == S_IDLE) begin
      // Without mute-on-loss the coder keeps running on the free-run count
      ltc_mute_q <= TC_LOST_I && MUTE_ON_LOSS_I;
      for (p = 0; p < 2; p = p + 1) begin
        if (ltc_cnt_q[p] == `AOR_LTC_HALF - 1) begin
          ltc_cnt_q[p] <= 4'd0;
          ltc_half_q[p] <= ~ltc_half_q[p];
          if (ltc_half_q[p]) begin
            ltc_lvl_q[p] <= ~ltc_lvl_q[p];
            if (ltc_bit_q[p] == `AOR_LTC_LAST_BIT) begin
              ltc_bit_q[p] <= 7'd0;
              ltc_word_q[p] <= (p == 0) ? LTC_TC_P1_I : LTC_TC_P2_I;
            end else begin
              ltc_bit_q[p] <= ltc_bit_q[p] + 1'b1;
            end
          end else if (ltc_word_q[p][ltc_bit_q[p]]) begin
            ltc_lvl_q[p] <= ~ltc_lvl_q[p];
          end
        end else begin
          ltc_cnt_q[p] <= ltc_cnt_q[p] + 1'b1;
        end
      end
    end
  end
endmodule

// file: rtl/aor_map.vh
/*
  Constants for the dual-path audio output router and mixer: channel counts,
  field widths, source codes, gain offsets, tone and LTC timing.
  Assumes one 25 MHz clock and a sample strobe at the audio sample rate.
*/
// Operation
// - Two output paths, sixteen embedded channels each, identical per-channel controls.
// - Each embedded channel selects tone, LTC path one/two, bus A-P, or silence.
// - Sixteen built-in tones at -20 dBFS, 100 Hz to 16 kHz.
// - Embedded channel gain -80 to +20 dB in 1 dB steps; 0 dB unity.
// - Every output channel has mute, invert and a post-gain peak meter.
// - Program path groups 1 to 4 individually enabled or disabled.
// - Group enable change may cause a brief noise burst on all groups.
// - Sixteen-input mixer; each input feeds one of buses A-P, which sum.
// - Mixer input selects silence or tone 1-16; separate bus selection.
// - Mixer input mute and gain -80 to +20 dB in 0.1 dB steps.
// - Bus outputs selectable by the crosspoints of both paths.
// - Each AES channel holds path one and two sources; toggle picks one.
// - AES channels have mute, invert, gain -80 to +20 dB in 1 dB steps.
// - LTC audio silent on timecode loss if mute-on-loss, else keeps running.
// - Reported output timecode is coded as audio LTC and offered as source.
`ifndef AOR_MAP_VH
`define AOR_MAP_VH

`define AOR_NCH 16
`define AOR_NEMB 32
`define AOR_NOUT 34
`define AOR_SMP_W 24
`define AOR_MAG_W 23
`define AOR_SRC_W 6
`define AOR_MSRC_W 5
`define AOR_BUS_W 4
`define AOR_EGAIN_W 7
`define AOR_MGAIN_W 10
`define AOR_CHAN_W 6
`define AOR_ACC_W 28
`define AOR_PH_W 16
`define AOR_LTC_BITS 80

`define AOR_SLOT_OUT0 6'd16
`define AOR_SLOT_AES0 6'd48
`define AOR_SLOT_LAST 6'd49
`define AOR_SRC_LTC1 6'd16
`define AOR_SRC_LTC2 6'd17
`define AOR_SRC_BUS0 6'd18
`define AOR_SRC_BUSN 6'd33
`define AOR_MSRC_TONE1 5'd1

// -20 dBFS of a 24-bit full scale
`define AOR_TONE_AMP 24'h0ccccd
`define AOR_SMP_MAX 24'h7fffff
`define AOR_SMP_MIN 24'h800000

// Gain index in tenths of dB, offset so unity falls at 16 octaves of 60 steps
`define AOR_GAIN_OFS 11'd160
`define AOR_GAIN_OCT 11'd60
`define AOR_GAIN_DB 6'd10
`define AOR_GAIN_UNITY_K 5'd16
`define AOR_EGAIN_MAX 7'd100
`define AOR_MGAIN_MAX 10'd1000
`define AOR_TAB_SHIFT 14

`define AOR_FS_HZ 48000
`define AOR_LTC_FPS 30
// Samples per half bit cell of LTC, rounded down
`define AOR_LTC_HALF (`AOR_FS_HZ / (`AOR_LTC_FPS * `AOR_LTC_BITS * 2))
`define AOR_LTC_LAST_BIT 7'd79

`define AOR_FIFO_DEPTH 8
`define AOR_FIFO_AW 3

`endif

// file: rtl/aor_fifo.v
/*
  Synchronous FIFO of flip-flops with valid/ready on both sides.
  Assumes one clock; a write with a full FIFO or a read when empty is ignored.
*/
`timescale 1ns/1ps
module aor_fifo #(
  parameter WIDTH = 30,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  integer i;

  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data_i;
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// file: bench/aor_router_sva.sv
/*
  Port assertions for the router: pass timing, overrun, output hold, mute,
  silence, group skip and meter clear.
  Assumes settings change only while the output stream is idle.
*/
`timescale 1ns/1ps
`include "aor_map.vh"
module aor_router_sva (
  input wire CLOCK_I,
  input wire ARST_N_I,
  input wire SAMPLE_STB_I,
  input wire [`AOR_NEMB*`AOR_SRC_W-1:0] EMB_SRC_I,
  input wire [`AOR_NEMB-1:0] EMB_MUTE_I,
  input wire [3:0] GRP_EN_I,
  input wire [2*`AOR_SRC_W-1:0] AES_SRC_P1_I,
  input wire [2*`AOR_SRC_W-1:0] AES_SRC_P2_I,
  input wire [1:0] AES_PATH_I,
  input wire [1:0] AES_MUTE_I,
  input wire PEAK_CLR_I,
  input wire OUT_READY_I,
  input wire OUT_VALID_O,
  input wire [`AOR_SMP_W-1:0] OUT_DATA_O,
  input wire [`AOR_CHAN_W-1:0] OUT_CHAN_O,
  input wire [`AOR_NOUT*`AOR_MAG_W-1:0] PEAK_O,
  input wire BUSY_O,
  input wire OVERRUN_O
);
  wire [4:0] ch = OUT_CHAN_O[4:0];
  wire a = OUT_CHAN_O[0];
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!ARST_N_I);
  // Upper bound covers a pass throttled by a slow sink
  property p_pass;
    SAMPLE_STB_I && !BUSY_O |=> BUSY_O[*8] ##[42:600] !BUSY_O;
  endproperty
  a_pass: assert property (p_pass) else $error("pass length wrong");
  property p_ovr;
    SAMPLE_STB_I && BUSY_O |=> OVERRUN_O;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");
  property p_hold;
    OUT_VALID_O && !OUT_READY_I |=> OUT_VALID_O && $stable(OUT_DATA_O) && $stable(OUT_CHAN_O);
  endproperty
  a_hold: assert property (p_hold) else $error("word dropped while stalled");
  property p_chan;
    OUT_VALID_O |-> OUT_CHAN_O < 6'd34;
  endproperty
  a_chan: assert property (p_chan) else $error("channel out of range");
  property p_grp;
    OUT_VALID_O && OUT_CHAN_O < 6'd16 |-> GRP_EN_I[OUT_CHAN_O[3:2]];
  endproperty
  a_grp: assert property (p_grp) else $error("disabled group emitted");
  property p_emute;
    OUT_VALID_O && !OUT_CHAN_O[5] && EMB_MUTE_I[ch] |-> OUT_DATA_O == 24'h0;
  endproperty
  a_emute: assert property (p_emute) else $error("muted channel not zero");
  property p_esil;
    OUT_VALID_O && !OUT_CHAN_O[5] && EMB_SRC_I[ch*6 +: 6] > 6'd33 |-> OUT_DATA_O == 24'h0;
  endproperty
  a_esil: assert property (p_esil) else $error("silence source not zero");
  property p_aes;
    OUT_VALID_O && OUT_CHAN_O[5] && (AES_MUTE_I[a] ||
      (AES_PATH_I[a] ? AES_SRC_P2_I[a*6 +: 6] : AES_SRC_P1_I[a*6 +: 6]) > 6'd33) |-> OUT_DATA_O == 24'h0;
  endproperty
  a_aes: assert property (p_aes) else $error("aes channel not silent");
  property p_clr;
    (PEAK_CLR_I && !BUSY_O)[*2] |=> PEAK_O == '0;
  endproperty
  a_clr: assert property (p_clr) else $error("meters not cleared");
endmodule

bind aor_router aor_router_sva u_sva (.CLOCK_I, .ARST_N_I, .SAMPLE_STB_I, .EMB_SRC_I, .EMB_MUTE_I, .GRP_EN_I,
  .AES_SRC_P1_I, .AES_SRC_P2_I, .AES_PATH_I, .AES_MUTE_I, .PEAK_CLR_I, .OUT_READY_I, .OUT_VALID_O,
  .OUT_DATA_O, .OUT_CHAN_O, .PEAK_O, .BUSY_O, .OVERRUN_O);

// file: bench/aor_sink.sv
/*
  Downstream embedder stand-in: takes words, keeps the last sample per channel.
  Assumes the router's output handshake; stall lets one cycle in four through.
*/
`timescale 1ns/1ps
`include "aor_map.vh"
module aor_sink (
  input wire clk_i,
  input wire stall_i,
  input wire valid_i,
  input wire [`AOR_SMP_W-1:0] data_i,
  input wire [`AOR_CHAN_W-1:0] chan_i,
  output reg ready_o
);
  reg [`AOR_SMP_W-1:0] smp [0:`AOR_NOUT-1];
  reg [1:0] cnt_q = 2'h0;
  reg [`AOR_CHAN_W-1:0] last_q = 6'h0;
  integer words = 0;
  integer order_err = 0;
  initial ready_o = 1'b1;
  // Ready moves off the sampling edge
  always @(negedge clk_i) begin
    cnt_q <= cnt_q + 2'h1;
    ready_o <= !stall_i || cnt_q == 2'h0;
  end
  // A new pass always restarts at or below channel 16
  always @(posedge clk_i) begin
    if (valid_i && ready_o) begin
      if (chan_i <= last_q && chan_i > 6'd16)
        order_err = order_err + 1;
      smp[chan_i] = data_i;
      last_q = chan_i;
      words = words + 1;
    end
  end
endmodule

// file: bench/tb.sv
/*
  Self-checking bench for the router: three sample passes with tone, gain,
  bus, LTC, group and AES settings, a stalled sink and an overrun.
  Assumes the sink model and the bound checker.
*/
`timescale 1ns/1ps
`include "aor_map.vh"
`define CHK(g, e) begin \
  num_checks = num_checks + 1; \
  if ((g) !== (e)) begin \
    bad_count = bad_count + 1; \
    $display("CHECK FAILED at %0t: got %h, expected %h", $time, (g), (e)); \
  end \
end
module tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg stb = 1'b0;
  reg tc_lost = 1'b0;
  reg mol = 1'b0;
  reg [79:0] tc = 80'h3ffd_0000_1234_0000_5678;
  reg [79:0] mix_src = 80'h0;
  reg [63:0] mix_bus = 64'h0;
  reg [159:0] mix_gain = {16{10'd800}};
  reg [15:0] mix_mute = 16'h0;
  reg [191:0] emb_src = {32{6'd63}};
  reg [223:0] emb_gain = {32{7'd80}};
  reg [31:0] emb_mute = 32'h0;
  reg [31:0] emb_inv = 32'h0;
  reg [3:0] grp = 4'hf;
  reg [11:0] aes_p1 = 12'h0;
  reg [11:0] aes_p2 = {6'd0, 6'd63};
  reg [1:0] aes_path = 2'h0;
  reg [1:0] aes_mute = 2'h2;
  reg [13:0] aes_gain = {2{7'd80}};
  reg [1:0] aes_inv = 2'h0;
  reg peak_clr = 1'b0;
  reg stall = 1'b0;
  wire ready, valid, busy, ovr;
  wire [23:0] data;
  wire [5:0] chan;
  wire [781:0] peak;
  integer bad_count = 0;
  integer num_checks = 0;
  integer i;
  aor_router dut (.CLOCK_I(clk), .ARST_N_I(rst_n), .SAMPLE_STB_I(stb), .TC_LOST_I(tc_lost),
    .MUTE_ON_LOSS_I(mol), .LTC_TC_P1_I(tc), .LTC_TC_P2_I(~tc), .MIX_SRC_I(mix_src), .MIX_BUS_I(mix_bus),
    .MIX_GAIN_I(mix_gain), .MIX_MUTE_I(mix_mute), .EMB_SRC_I(emb_src), .EMB_GAIN_I(emb_gain),
    .EMB_MUTE_I(emb_mute), .EMB_INV_I(emb_inv), .GRP_EN_I(grp), .AES_SRC_P1_I(aes_p1),
    .AES_SRC_P2_I(aes_p2), .AES_PATH_I(aes_path), .AES_GAIN_I(aes_gain), .AES_MUTE_I(aes_mute),
    .AES_INV_I(aes_inv), .PEAK_CLR_I(peak_clr), .OUT_READY_I(ready), .OUT_VALID_O(valid),
    .OUT_DATA_O(data), .OUT_CHAN_O(chan), .PEAK_O(peak), .BUSY_O(busy), .OVERRUN_O(ovr));
  aor_sink u_sink (.clk_i(clk), .stall_i(stall), .valid_i(valid), .data_i(data), .chan_i(chan),
    .ready_o(ready));
  initial forever #20 clk = ~clk;
  // Magnitude with the negative full scale folded onto the positive
  function [23:0] mag(input [23:0] x);
    begin
      if (!x[23]) mag = x;
      else if (x == 24'h800000) mag = 24'h7fffff;
      else mag = 24'h0 - x;
    end
  endfunction
  task give_verdict;
    begin
      $display("bad_count=%0d num_checks=%0d", bad_count, num_checks);
      if (bad_count == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task run_pass(input integer n, input reg try_ovr);
    integer w0, k;
    begin
      w0 = u_sink.words;
      @(negedge clk) stb = 1'b1;
      @(negedge clk) stb = 1'b0;
      `CHK(busy, 1'b1)
      if (try_ovr) begin
        repeat (4) @(negedge clk);
        stb = 1'b1;
        @(negedge clk) stb = 1'b0;
        `CHK(ovr, 1'b1)
      end
      k = 0;
      while (k < 800 && (busy !== 1'b0 || u_sink.words != w0 + n)) begin
        @(negedge clk);
        k = k + 1;
      end
      if (k == 800) begin
        bad_count = bad_count + 1;
        give_verdict;
      end
      repeat (5) @(negedge clk);
      `CHK(u_sink.words, w0 + n)
    end
  endtask
  initial begin
    for (i = 0; i < 5; i = i + 1)
      emb_src[i*6 +: 6] = 6'd0;
    emb_src[35:30] = 6'd18;
    emb_src[41:36] = 6'd16;
    emb_src[131:126] = 6'd18;
    emb_inv[1] = 1'b1;
    emb_gain[20:14] = 7'd86;
    emb_mute[3] = 1'b1;
    emb_gain[34:28] = 7'd100;
    mix_src[9:0] = {5'd1, 5'd1};
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    run_pass(34, 1'b1);
    `CHK(mag(u_sink.smp[0]), 24'h0ccccd)
    `CHK(u_sink.smp[0] + u_sink.smp[1], 24'h0)
    `CHK(mag(u_sink.smp[2]), 24'h19999a)
    `CHK(u_sink.smp[3], 24'h0)
    `CHK(mag(u_sink.smp[4]), 24'h7fffff)
    `CHK(mag(u_sink.smp[5]), 24'h19999a)
    `CHK(mag(u_sink.smp[21]), 24'h19999a)
    `CHK(u_sink.smp[7], 24'h0)
    `CHK(u_sink.smp[6] != 24'h0, 1'b1)
    `CHK(mag(u_sink.smp[32]), 24'h0ccccd)
    `CHK(u_sink.smp[33], 24'h0)
    `CHK(peak[22:0], 23'h0ccccd)
    `CHK(peak[45:23], 23'h0ccccd)
    `CHK(peak[68:46], 23'h19999a)
    `CHK(peak[91:69], 23'h0ccccd)
    mix_mute[1] = 1'b1;
    tc_lost = 1'b1;
    mol = 1'b1;
    aes_path[0] = 1'b1;
    grp = 4'he;
    stall = 1'b1;
    u_sink.smp[0] = 24'h555555;
    peak_clr = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(peak === 782'h0, 1'b1)
    peak_clr = 1'b0;
    run_pass(30, 1'b0);
    `CHK(u_sink.smp[0], 24'h555555)
    `CHK(mag(u_sink.smp[5]), 24'h0ccccd)
    `CHK(u_sink.smp[6], 24'h0)
    `CHK(u_sink.smp[32], 24'h0)
    `CHK(u_sink.order_err, 0)
    mol = 1'b0;
    grp = 4'hf;
    stall = 1'b0;
    aes_path[0] = 1'b0;
    aes_inv[0] = 1'b1;
    aes_gain[6:0] = 7'd86;
    emb_src[47:42] = 6'd17;
    emb_src[131:126] = 6'd19;
    mix_bus[7:4] = 4'd1;
    mix_mute[1] = 1'b0;
    mix_gain[9:0] = 10'd860;
    run_pass(34, 1'b0);
    `CHK(u_sink.smp[6] != 24'h0, 1'b1)
    `CHK(mag(u_sink.smp[0]), 24'h0ccccd)
    `CHK(u_sink.smp[7] != 24'h0, 1'b1)
    `CHK(mag(u_sink.smp[5]), 24'h19999a)
    `CHK(mag(u_sink.smp[21]), 24'h0ccccd)
    `CHK(mag(u_sink.smp[32]), 24'h19999a)
    `CHK(u_sink.smp[32] + u_sink.smp[0] + u_sink.smp[0], 24'h0)
    give_verdict;
  end
endmodule
